// ---- verilog/iea_top.sv ----
// interrupt event aggregator with axi4-lite register slave
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "iea_consts.svh"
module iea_top
  import iea_pkg::*;
(
  // clock and main well reset
  input wire logic aclk,
  input wire logic aresetn,
  // internal event sources, group g bits at [32*g +: 32]
  input wire logic [511:0] events,
  // write address
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // read address
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // processor interrupt lines, bit g drives port g
  output logic [15:0] group_irq,
  // per-bit results to the nested vectored controller
  output logic [511:0] nested_vectored_controller,
  // summary interrupt
  output logic irq
);
  // private bus only, no pins, one well, no power control
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_DO = 3'b010,
    WR_RESP = 3'b100
  } iea_wr_t;

  iea_wr_t wr_r;
  logic aw_have_r;
  logic w_have_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [15:0] blk_sel_r;
  logic route_en_r;
  logic [15:0] grp_stat_r;
  logic [15:0] irq_mask_r;
  logic [511:0] src_all;
  logic [511:0] en_all;
  logic [511:0] res_all;
  logic [511:0] src_clr;
  logic [511:0] en_set;
  logic [511:0] en_clr;
  logic [31:0] wmask;
  logic wr_fire;
  logic [31:0] wbe;
  logic blk_sel_wr;
  logic ctrl_wr;
  logic stat_wr;
  logic mask_wr;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;
  logic [3:0] ar_grp;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // aligned word inside the sixteen group blocks
  function automatic logic in_groups(input logic [11:0] a);
    in_groups = (a < 12'h100) && (a[1:0] == 2'h0);
  endfunction

  // true when address a names word ofs of group gi
  function automatic logic grp_word(input logic [11:0] a, input logic [3:0] gi,
    input logic [3:0] ofs);
    grp_word = in_groups(a) && (a[7:4] == gi) && (a[3:0] == ofs);
  endfunction

  // any word the slave answers with okay; everything else is refused
  function automatic logic known_addr(input logic [11:0] a);
    known_addr = in_groups(a) || (a == `IEA_BLK_SEL_ADDR) || (a == `IEA_CTRL_ADDR) ||
      (a == `IEA_GRP_STAT_ADDR) || (a == `IEA_IRQ_MASK_ADDR);
  endfunction

  assign wbe = strb_mask(wstrb_r);
  assign wmask = wbe & wdata_r;
  assign wr_fire = (wr_r == WR_DO);

  // one strobe per control word, decoded once from the held address
  assign blk_sel_wr = wr_fire && (awaddr_r == `IEA_BLK_SEL_ADDR);
  assign ctrl_wr = wr_fire && (awaddr_r == `IEA_CTRL_ADDR);
  assign stat_wr = wr_fire && (awaddr_r == `IEA_GRP_STAT_ADDR);
  assign mask_wr = wr_fire && (awaddr_r == `IEA_IRQ_MASK_ADDR);

  genvar g;
  generate
    for (g = 0; g < `IEA_NGROUPS; g = g + 1) begin : grp
      assign src_clr[32*g +: 32] =
        (wr_fire && grp_word(awaddr_r, 4'(g), `IEA_SRC_OFS)) ? wmask : 32'h0;
      assign en_set[32*g +: 32] =
        (wr_fire && grp_word(awaddr_r, 4'(g), `IEA_EN_SET_OFS)) ? wmask : 32'h0;
      assign en_clr[32*g +: 32] =
        (wr_fire && grp_word(awaddr_r, 4'(g), `IEA_EN_CLR_OFS)) ? wmask : 32'h0;
      iea_group u_grp (
        .aclk(aclk),
        .aresetn(aresetn),
        .events(events[32*g +: 32]),
        .src_clr(src_clr[32*g +: 32]),
        .en_set(en_set[32*g +: 32]),
        .en_clr(en_clr[32*g +: 32]),
        .blk_sel(blk_sel_r[g]),
        .source(src_all[32*g +: 32]),
        .enable(en_all[32*g +: 32]),
        .result(res_all[32*g +: 32]),
        .line(group_irq[g])
      );
    end
  endgenerate

  assign nested_vectored_controller = route_en_r ? res_all : 512'h0;

  // write channel: address and data accepted in either order
  assign s_awready = (wr_r == WR_IDLE) && !aw_have_r;
  assign s_wready = (wr_r == WR_IDLE) && !w_have_r;
  assign s_bvalid = (wr_r == WR_RESP);
  assign s_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      awaddr_r <= 12'h0;
    end else if (s_awvalid && s_awready) begin
      aw_have_r <= 1'b1;
      awaddr_r <= s_awaddr;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      w_have_r <= 1'b1;
      wdata_r <= s_wdata;
      wstrb_r <= s_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  // response waits for both halves; a lone address or data word is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_r <= WR_IDLE;
    end else begin
      case (wr_r)
        WR_IDLE: begin
          if (aw_have_r && w_have_r) begin
            wr_r <= WR_DO;
          end
        end
        WR_DO: begin
          wr_r <= WR_RESP;
        end
        WR_RESP: begin
          if (s_bready) begin
            wr_r <= WR_IDLE;
          end
        end
        default: begin
          wr_r <= WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_r <= IEA_OKAY;
    end else if (wr_fire) begin
      if (known_addr(awaddr_r)) begin
        bresp_r <= IEA_OKAY;
      end else begin
        bresp_r <= IEA_SLVERR;
      end
    end
  end

  // control registers; writes to read-only result words are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_sel_r <= 16'h0;
    end else if (blk_sel_wr) begin
      blk_sel_r <= (blk_sel_r & ~wbe[15:0]) | wmask[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_en_r <= 1'b0;
    end else if (ctrl_wr && wstrb_r[0]) begin
      route_en_r <= wdata_r[`IEA_CTRL_ROUTE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= 16'h0;
    end else if (mask_wr) begin
      irq_mask_r <= (irq_mask_r & ~wbe[15:0]) | wmask[15:0];
    end
  end

  // sticky summary: a group line rising edge is not tracked, the level sets it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grp_stat_r <= 16'h0;
    end else if (stat_wr) begin
      grp_stat_r <= (grp_stat_r & ~wmask[15:0]) | group_irq;
    end else begin
      grp_stat_r <= grp_stat_r | group_irq;
    end
  end

  assign irq = |(grp_stat_r & irq_mask_r);

  // read channel: one cycle to rvalid
  assign s_arready = !rvalid_r;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
    end else if (s_arvalid && s_arready) begin
      rvalid_r <= 1'b1;
    end else if (s_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // read word picked from the address on the bus, captured when the address is taken
  assign ar_grp = s_araddr[7:4];

  always_comb begin
    rdata_nxt = 32'h0;
    rresp_nxt = IEA_OKAY;
    if (!known_addr(s_araddr)) begin
      rresp_nxt = IEA_SLVERR;
    end else if (in_groups(s_araddr)) begin
      if (s_araddr[3:0] == `IEA_SRC_OFS) begin
        rdata_nxt = src_all[32*ar_grp +: 32];
      end else if (s_araddr[3:0] == `IEA_RESULT_OFS) begin
        rdata_nxt = res_all[32*ar_grp +: 32];
      end else begin
        rdata_nxt = en_all[32*ar_grp +: 32];
      end
    end else if (s_araddr == `IEA_BLK_SEL_ADDR) begin
      rdata_nxt = {16'h0, blk_sel_r};
    end else if (s_araddr == `IEA_CTRL_ADDR) begin
      rdata_nxt = {31'h0, route_en_r};
    end else if (s_araddr == `IEA_GRP_STAT_ADDR) begin
      rdata_nxt = {16'h0, grp_stat_r};
    end else if (s_araddr == `IEA_IRQ_MASK_ADDR) begin
      rdata_nxt = {16'h0, irq_mask_r};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= 32'h0;
      rresp_r <= IEA_OKAY;
    end else if (s_arvalid && s_arready) begin
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/iea_consts.svh ----
// constants and rule summary for the interrupt event aggregator
// Operation
// - sixteen groups, each with source, enable and result registers
// - source and enable bits are held in storage, not following input levels
// - result bit is source bit AND enable bit of the same group
// - group line is OR of result bits AND the group's block select bit
// - vectored routing enable forwards individual result bits to the vectored controller
// - registers reachable only by the embedded processor's private bus
// - no external pins; all inputs and outputs are internal signals
// - whole block sits on the single main standby well
// - main well reset returns all logic and registers to defaults
// - group number equals the processor interrupt port it drives
// - block runs in lowest power automatically, no power-mode control
`ifndef IEA_CONSTS_SVH
`define IEA_CONSTS_SVH
`define IEA_NGROUPS 16
`define IEA_GROUP_STRIDE 32'h0000_0010
`define IEA_SRC_OFS 4'h0
`define IEA_EN_SET_OFS 4'h4
`define IEA_EN_CLR_OFS 4'h8
`define IEA_RESULT_OFS 4'hc
`define IEA_BLK_SEL_ADDR 12'h200
`define IEA_CTRL_ADDR 12'h204
`define IEA_GRP_STAT_ADDR 12'h208
`define IEA_IRQ_MASK_ADDR 12'h20c
`define IEA_CTRL_ROUTE_BIT 0
`define IEA_RESET_WORD 32'h0000_0000
`endif

// ---- verilog/iea_pkg.sv ----
// types for the interrupt event aggregator
package iea_pkg;
  typedef logic [31:0] iea_word_t;
  typedef logic [1:0] iea_resp_t;
  localparam iea_resp_t IEA_OKAY = 2'h0;
  localparam iea_resp_t IEA_SLVERR = 2'h2;
endpackage

// ---- verilog/iea_group.sv ----
// one aggregation group: latched source and enable words, combined line
`timescale 1ns/100ps
`default_nettype none
`include "iea_consts.svh"
module iea_group
  import iea_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // event inputs
  input wire logic [31:0] events,
  // software access
  input wire logic [31:0] src_clr,
  input wire logic [31:0] en_set,
  input wire logic [31:0] en_clr,
  input wire logic blk_sel,
  // outputs
  output logic [31:0] source,
  output logic [31:0] enable,
  output logic [31:0] result,
  output logic line
);
  logic [31:0] source_r;
  logic [31:0] enable_r;

  // set beats clear so an event coinciding with a clear is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_r <= `IEA_RESET_WORD;
    end else begin
      source_r <= (source_r & ~src_clr) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= `IEA_RESET_WORD;
    end else begin
      enable_r <= (enable_r & ~en_clr) | en_set;
    end
  end

  assign source = source_r;
  assign enable = enable_r;
  assign result = source_r & enable_r;
  assign line = (|result) & blk_sel;
endmodule
`default_nettype wire

// ---- verification/iea_asserts.sv ----
// port checker for the interrupt event aggregator
`timescale 1ns/100ps
`default_nettype none
module iea_asserts
  import iea_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  // interrupt outputs
  input wire logic [15:0] group_irq,
  input wire logic [511:0] nested_vectored_controller,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic ar_go = s_arvalid && s_arready;
  wire logic w_go = s_awvalid && s_awready && s_wvalid && s_wready;
  reset_zero_a: assert property ($rose(aresetn) |-> group_irq == 16'h0 && !irq)
    else $error("outputs not clear after reset");
  read_answer_a: assert property (ar_go |=> s_rvalid)
    else $error("read answer late");
  unmapped_read_a: assert property (ar_go && s_araddr >= 12'h210 |=> s_rresp == IEA_SLVERR && s_rdata == 32'h0)
    else $error("unmapped read not refused");
  write_answer_a: assert property (w_go |-> ##1 !s_bvalid ##1 !s_bvalid ##1 s_bvalid)
    else $error("write answer timing");
  busy_refuse_a: assert property (s_bvalid |-> !s_awready && !s_wready && !(s_rvalid && s_arready))
    else $error("request taken while busy");
  // a line may only fall through a register write, never by the event input going low
  line_drop_a: assert property ($past(aresetn) && |($past(group_irq) & ~group_irq) |-> s_bvalid)
    else $error("group line fell without a write");
  irq_cause_a: assert property ($rose(irq) |-> $past(group_irq) != 16'h0 || s_bvalid)
    else $error("summary irq without cause");
  for (genvar g = 0; g < 16; g++) begin : grp
    route_or_a: assert property (group_irq[g] && |nested_vectored_controller |-> |nested_vectored_controller[32*g +: 32])
      else $error("routed bits miss a live group");
  end
  cover property (w_go);
  cover property ($rose(irq));
  cover property (|nested_vectored_controller);
endmodule
`default_nettype wire

// ---- verification/iea_nvc_model.sv ----
// behavioural vectored controller latching group lines as pending
`timescale 1ns/100ps
`default_nettype none
module iea_nvc_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // group lines and bench acknowledge
  input wire logic [15:0] group_irq,
  input wire logic ack,
  // pending ports
  output logic [15:0] pend
);
  // lines are levels: ack only sticks once the source is gone
  always_ff @(posedge aclk) begin
    if (!aresetn || ack) begin
      pend <= 16'h0;
    end else begin
      pend <= pend | group_irq;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the interrupt event aggregator
`timescale 1ns/100ps
`default_nettype none
`include "iea_consts.svh"
module tb_top
  import iea_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, ack = 1'b0;
  logic [511:0] ev = '0, nvc;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [15:0] gi, pend;
  int failures = 0, checks_done = 0;
  always #4 aclk = ~aclk;
  iea_top dut (.aclk(aclk), .aresetn(aresetn), .events(ev), .s_awaddr(awaddr),
    .s_awvalid(awv), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wv),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arv), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .group_irq(gi),
    .nested_vectored_controller(nvc), .irq(irq));
  iea_nvc_model nvm (.aclk(aclk), .aresetn(aresetn), .group_irq(gi), .ack(ack), .pend(pend));
  task chk(string n, logic [511:0] s, logic [511:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r = IEA_OKAY);
    logic da = 1'b0, dw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    // each channel released on its own acceptance edge
    while (!(da && dw)) begin
      @(negedge aclk);
      if (awv && awready) da = 1'b1;
      if (wv && wready) dw = 1'b1;
      @(posedge aclk);
      if (da) awv <= 1'b0;
      if (dw) wv <= 1'b0;
    end
    bready <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk("bresp", bresp, r);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] r = IEA_OKAY);
    araddr <= a;
    arv <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arv <= 1'b0;
    rready <= 1'b1;
    do @(negedge aclk); while (rvalid !== 1'b1);
    chk("rdata", rdata, e);
    chk("rresp", rresp, r);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  function logic [11:0] ga(int g, logic [3:0] o);
    return 12'(16 * g) | 12'(o);
  endfunction
  function logic [511:0] bit_of(int g, int b);
    return 512'h1 << (32 * g + b);
  endfunction
  task pulse(int g, int b);
    ev <= bit_of(g, b);
    @(posedge aclk);
    ev <= '0;
  endtask
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  initial begin
    int g, b;
    void'($urandom(32'h2bb3ebe1));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`IEA_CTRL_ADDR, 32'h0);
    rd(`IEA_BLK_SEL_ADDR, 32'h0);
    rd(ga(15, `IEA_EN_SET_OFS), 32'h0);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      // first and last groups and bits forced as corner cases
      g = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(15);
      b = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(31);
      pulse(g, b);
      rd(ga(g, `IEA_SRC_OFS), 32'h1 << b);
      wr(ga(g, `IEA_SRC_OFS), ~(32'h1 << b));
      rd(ga(g, `IEA_SRC_OFS), 32'h1 << b);
      wr(ga(g, `IEA_EN_SET_OFS), 32'h1 << b);
      rd(ga(g, `IEA_RESULT_OFS), 32'h1 << b);
      chk("line unselected", gi, 16'h0);
      wr(`IEA_BLK_SEL_ADDR, 32'h1 << g);
      chk("line", gi, 16'h1 << g);
      chk("masked irq", irq, 1'b0);
      wr(`IEA_IRQ_MASK_ADDR, 32'h1 << g);
      chk("irq", irq, 1'b1);
      chk("port", pend, 16'h1 << g);
      chk("routed off", nvc, 512'h0);
      wr(`IEA_CTRL_ADDR, 32'h1);
      chk("routed", nvc, bit_of(g, b));
      wr(ga(g, `IEA_SRC_OFS), 32'h1 << b);
      rd(ga(g, `IEA_SRC_OFS), 32'h0);
      chk("line cleared", gi, 16'h0);
      wr(`IEA_GRP_STAT_ADDR, 32'h1 << g);
      chk("irq cleared", irq, 1'b0);
      wr(ga(g, `IEA_EN_CLR_OFS), 32'h1 << b);
      rd(ga(g, `IEA_EN_SET_OFS), 32'h0);
      wr(`IEA_CTRL_ADDR, 32'h0);
      wr(`IEA_BLK_SEL_ADDR, 32'h0);
      wr(`IEA_IRQ_MASK_ADDR, 32'h0);
      ack <= 1'b1;
      @(posedge aclk);
      ack <= 1'b0;
    end
    $display("test group_paths done");
    wr(12'h300, 32'hffff_ffff, IEA_SLVERR);
    rd(12'h300, 32'h0, IEA_SLVERR);
    wstrb <= 4'h1;
    wr(`IEA_BLK_SEL_ADDR, 32'hffff_ffff);
    wstrb <= 4'hf;
    rd(`IEA_BLK_SEL_ADDR, 32'h0000_00ff);
    $display("test unmapped done");
    pulse(3, 7);
    wr(ga(3, `IEA_EN_SET_OFS), 32'h80);
    wr(`IEA_BLK_SEL_ADDR, 32'h8);
    chk("line before reset", gi, 16'h8);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("line after reset", gi, 16'h0);
    rd(ga(3, `IEA_SRC_OFS), 32'h0);
    rd(`IEA_BLK_SEL_ADDR, 32'h0);
    $display("test mid_reset done");
    stop_test();
  end
endmodule
bind iea_top iea_asserts chk_i (.aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid),
  .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
  .s_rresp(s_rresp), .s_rvalid(s_rvalid), .group_irq(group_irq), .irq(irq),
  .nested_vectored_controller(nested_vectored_controller));
`default_nettype wire
